// >>> verilog/dcp_pkg.sv
// dcp_pkg: register map, field layout and carriers of one dma channel
// assumes one 50 MHz clock domain shared by apb, engine and system bus
//
// Behaviour
// - internal request mode starts on run bit
// - external requests ignored until run bit set
// - run bit clear halts, resume keeps state
// - channel clears run bit on completion
// - run bit reads one until operand done
// - source pointer addresses every read cycle
// - source steps 1/2/4 by size, alignment, wraps
// - destination pointer addresses every write cycle
// - destination steps 1/2/4 by size, alignment, wraps
// - pointers loadable by host or microcode
// - space code: upper nibble write, lower read
// - count steps down per byte, zero ends
// - status sticky, write one clears bits
// - auxiliary done on interrupt-flagged non-last descriptor end
// - breakpoint during transfer sets bit four
// - descriptors exhausted flag in microcode mode
// - bus errors set bits, stop without done
// - done only on error-free normal termination
// - mask enables matching status bit interrupt
// - seven byte buffer packs and unpacks operands
// - active-low request, acknowledge during peripheral access
// - end line driven on last, input terminates
// - request select: limited, max, level, edge
// - size field: long, byte, word, reserved
// - software reset aborts, clears status and mode
package dcp_pkg;
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_SRC = 8'h04;
  localparam logic [7:0] OFS_DST = 8'h08;
  localparam logic [7:0] OFS_FC = 8'h0C;
  localparam logic [7:0] OFS_CNT = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_MASK = 8'h18;
  // mode register fields
  localparam int M_RUN = 0;
  localparam int M_SRST = 1;
  localparam int M_REQ = 2;
  localparam int M_SINC = 4;
  localparam int M_DINC = 5;
  localparam int M_SSZ = 6;
  localparam int M_DSZ = 8;
  localparam int M_UCM = 10;
  localparam int M_PSRC = 11;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [7:0] FC_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  // status bits
  localparam int S_DONE = 0;
  localparam int S_WERR = 1;
  localparam int S_RERR = 2;
  localparam int S_OB = 3;
  localparam int S_BRK = 4;
  localparam int S_AD = 5;
  localparam logic [1:0] REQ_LIMITED = 2'h0;
  localparam logic [1:0] REQ_MAX = 2'h1;
  localparam logic [1:0] REQ_LEVEL = 2'h2;
  localparam logic [1:0] REQ_EDGE = 2'h3;
  localparam logic [1:0] SZ_LONG = 2'h0;
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  // one less than the cycles from one operand start until the next may start in limited-rate mode
  localparam int LIMIT_GAP = 15;

  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic [2:0] nbytes;
    logic [3:0] space;
    logic [31:0] wdata;
  } dcp_bus_cmd_t;

  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] count;
    logic irq;
    logic last;
  } dcp_desc_t;
endpackage

// >>> verilog/dcp_channel.sv
// dcp_channel: one dma channel with apb registers and system bus master
// assumes bus_* and desc_* are on sys_clk; peripheral pins are async
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module dcp_channel #(
  parameter int unsigned GAP = dcp_pkg::LIMIT_GAP
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic bus_req,
  output dcp_pkg::dcp_bus_cmd_t bus_cmd,
  input wire logic bus_ack,
  input wire logic bus_err,
  input wire logic [31:0] bus_rdata,
  output logic [3:0] space_code_outputs,
  input wire logic desc_load,
  input wire dcp_pkg::dcp_desc_t desc_in,
  input wire logic desc_none,
  output logic buffer_served,
  input wire logic breakpoint,
  input wire logic periph_request_n,
  output logic periph_acknowledge_n,
  input wire logic transfer_end_n_in,
  output logic transfer_end_n_out,
  output logic transfer_end_n_oe,
  output logic chan_irq
);
  typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_WAIT} dcp_state_t;

  dcp_state_t state_q;
  logic run_q, stop_q, bus_req_q, drv_q, ack_n_q, edge_q;
  logic last_q, irq_q, served_q;
  logic [15:0] mode_q;
  logic [31:0] src_q, dst_q, cnt_q, prdata_q;
  logic [7:0] fc_q, stat_q, mask_q, gap_q, st_set;
  logic [55:0] hold_q;
  logic [2:0] held_q, wstep, rstep, nb;
  dcp_pkg::dcp_bus_cmd_t bus_cmd_q, nxt_cmd;
  logic req_s1, req_s2, req_p, end_s1, end_s2;
  logic err_q, wr, srst, busy, ext, ucm, go, op_wr, ext_end;
  logic beat, berr, wbeat, rbeat, fin, ev_done;
  logic [32:0] cnt33, rd_left;
  logic [31:0] cnt_nxt, rd_m;

  // ------------------------------------------------------------
  // step size
  // ------------------------------------------------------------
  // largest legal step for port size, alignment and bytes left
  function automatic logic [2:0] step_f(input logic [1:0] sz,
      input logic [1:0] a, input logic [32:0] left);
    step_f = 3'h1;
    if (sz == dcp_pkg::SZ_LONG && a == 2'h0 && left >= 33'h4) begin
      step_f = 3'h4;
    end else if (sz != dcp_pkg::SZ_BYTE && !a[0] && left >= 33'h2) begin
      step_f = 3'h2;
    end
  endfunction

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  assign wr = psel && penable && pwrite;
  assign srst = wr && paddr == dcp_pkg::OFS_MODE && pwdata[dcp_pkg::M_SRST];
  assign busy = state_q == ST_BUSY;
  assign ext = mode_q[dcp_pkg::M_REQ+1];
  assign ucm = mode_q[dcp_pkg::M_UCM];
  assign nb = bus_cmd_q.nbytes;
  // a zero count stands for the full 4 gigabytes
  assign cnt33 = {cnt_q == 32'h0, cnt_q};
  assign rd_left = cnt33 - 33'(held_q);
  assign wstep = step_f(mode_q[dcp_pkg::M_DSZ+:2], dst_q[1:0], cnt33);
  assign rstep = step_f(mode_q[dcp_pkg::M_SSZ+:2], src_q[1:0], rd_left);
  assign op_wr = held_q != 3'h0 && held_q >= wstep;
  // own drive is excluded so the final write does not end itself
  assign ext_end = !end_s2 && !drv_q;

  always_comb begin
    unique case (mode_q[dcp_pkg::M_REQ+:2])
      dcp_pkg::REQ_LIMITED: go = gap_q == 8'h0;
      dcp_pkg::REQ_MAX: go = 1'h1;
      dcp_pkg::REQ_LEVEL: go = !req_s2;
      dcp_pkg::REQ_EDGE: go = edge_q;
    endcase
  end

  always_comb begin
    nxt_cmd.addr = op_wr ? dst_q : src_q;
    nxt_cmd.write = op_wr;
    nxt_cmd.nbytes = op_wr ? wstep : rstep;
    nxt_cmd.space = op_wr ? fc_q[7:4] : fc_q[3:0];
    nxt_cmd.wdata = hold_q[31:0];
  end

  assign beat = busy && (bus_ack || bus_err);
  assign berr = busy && bus_err;
  assign wbeat = beat && !bus_err && bus_cmd_q.write;
  assign rbeat = beat && !bus_err && !bus_cmd_q.write;
  assign cnt_nxt = cnt_q - 32'(nb);
  assign fin = wbeat && cnt_nxt == 32'h0;
  assign rd_m = bus_rdata & (nb == 3'h1 ? 32'h0000_00FF :
                nb == 3'h2 ? 32'h0000_FFFF : 32'hFFFF_FFFF);
  // errors suppress done; external end counts outside error beats
  assign ev_done = !berr && ((fin && (!ucm || last_q)) ||
                   (run_q && ext_end && (beat || state_q == ST_IDLE)));

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_s1 <= 1'h1;
      req_s2 <= 1'h1;
      req_p <= 1'h1;
      end_s1 <= 1'h1;
      end_s2 <= 1'h1;
    end else begin
      req_s1 <= periph_request_n;
      req_s2 <= req_s1;
      req_p <= req_s2;
      end_s1 <= transfer_end_n_in;
      end_s2 <= end_s1;
    end
  end

  // ------------------------------------------------------------
  // transfer engine
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      run_q <= 1'h0;
      stop_q <= 1'h0;
      mode_q <= dcp_pkg::MODE_RST;
      src_q <= 32'h0;
      dst_q <= 32'h0;
      cnt_q <= 32'h0;
      hold_q <= 56'h0;
      held_q <= 3'h0;
      bus_req_q <= 1'h0;
      bus_cmd_q <= '0;
      drv_q <= 1'h0;
      ack_n_q <= 1'h1;
      gap_q <= 8'h0;
      edge_q <= 1'h0;
      last_q <= 1'h0;
      irq_q <= 1'h0;
      served_q <= 1'h0;
    end else begin
      served_q <= 1'h0;
      if (wr && paddr == dcp_pkg::OFS_MODE) begin
        mode_q <= {pwdata[15:2], 2'h0};
        if (pwdata[dcp_pkg::M_RUN]) begin
          run_q <= 1'h1;
          stop_q <= 1'h0;
        end else if (run_q) begin
          stop_q <= 1'h1;
        end
      end
      // pointers cannot move under a running bus cycle
      if (wr && !busy && paddr == dcp_pkg::OFS_SRC) src_q <= pwdata;
      if (wr && !busy && paddr == dcp_pkg::OFS_DST) dst_q <= pwdata;
      if (wr && !busy && paddr == dcp_pkg::OFS_CNT) cnt_q <= pwdata;
      if (ucm && desc_load && !busy) begin
        src_q <= desc_in.src;
        dst_q <= desc_in.dst;
        cnt_q <= desc_in.count;
        irq_q <= desc_in.irq;
        last_q <= desc_in.last;
        if (state_q == ST_WAIT) state_q <= ST_IDLE;
      end
      if (gap_q != 8'h0) gap_q <= gap_q - 8'h1;
      if (req_p && !req_s2 && run_q && ext) edge_q <= 1'h1;
      unique case (state_q)
        ST_IDLE: begin
          if (run_q && ext_end) begin
            run_q <= 1'h0;
            stop_q <= 1'h0;
            held_q <= 3'h0;
          end else if (run_q && stop_q && held_q == 3'h0) begin
            run_q <= 1'h0;
            stop_q <= 1'h0;
          end else if (held_q != 3'h0 || (run_q && go)) begin
            bus_req_q <= 1'h1;
            bus_cmd_q <= nxt_cmd;
            state_q <= ST_BUSY;
            drv_q <= op_wr && cnt33 == 33'(wstep);
            ack_n_q <= !(ext && (op_wr != mode_q[dcp_pkg::M_PSRC]));
            if (held_q == 3'h0) begin
              gap_q <= 8'(GAP);
              edge_q <= 1'h0;
            end
          end
        end
        ST_BUSY: begin
          if (beat) begin
            bus_req_q <= 1'h0;
            drv_q <= 1'h0;
            ack_n_q <= 1'h1;
            state_q <= ST_IDLE;
          end
          if (berr) begin
            run_q <= 1'h0;
            stop_q <= 1'h0;
            held_q <= 3'h0;
          end else if (wbeat) begin
            hold_q <= hold_q >> {nb, 3'h0};
            held_q <= held_q - nb;
            cnt_q <= cnt_nxt;
            if (mode_q[dcp_pkg::M_DINC]) dst_q <= dst_q + 32'(nb);
            if (fin) begin
              served_q <= ucm;
              if (!ucm || last_q) begin
                run_q <= 1'h0;
                stop_q <= 1'h0;
              end else begin
                state_q <= ST_WAIT;
              end
            end
          end else if (rbeat) begin
            hold_q <= hold_q | (56'(rd_m) << {held_q, 3'h0});
            held_q <= held_q + nb;
            if (mode_q[dcp_pkg::M_SINC]) src_q <= src_q + 32'(nb);
          end
          if (beat && !berr && run_q && ext_end) begin
            run_q <= 1'h0;
            stop_q <= 1'h0;
            held_q <= 3'h0;
            state_q <= ST_IDLE;
          end
        end
        ST_WAIT: begin
          if (desc_none || stop_q) begin
            run_q <= 1'h0;
            stop_q <= 1'h0;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
      if (srst) begin
        // abort: bus cycle dropped, channel stopped, mode cleared
        mode_q <= dcp_pkg::MODE_RST;
        run_q <= 1'h0;
        stop_q <= 1'h0;
        state_q <= ST_IDLE;
        bus_req_q <= 1'h0;
        held_q <= 3'h0;
        drv_q <= 1'h0;
        ack_n_q <= 1'h1;
        edge_q <= 1'h0;
      end
    end
  end

  // ------------------------------------------------------------
  // status and mask
  // ------------------------------------------------------------
  always_comb begin
    st_set = 8'h00;
    st_set[dcp_pkg::S_DONE] = ev_done;
    st_set[dcp_pkg::S_WERR] = berr && bus_cmd_q.write;
    st_set[dcp_pkg::S_RERR] = berr && !bus_cmd_q.write;
    st_set[dcp_pkg::S_OB] = ucm && state_q == ST_WAIT && desc_none;
    st_set[dcp_pkg::S_BRK] = breakpoint && busy;
    st_set[dcp_pkg::S_AD] = fin && ucm && !last_q && irq_q;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_q <= dcp_pkg::STAT_RST;
    end else if (srst) begin
      stat_q <= dcp_pkg::STAT_RST;
    end else if (wr && paddr == dcp_pkg::OFS_STAT) begin
      // a new event in the clearing cycle survives
      stat_q <= (stat_q & ~pwdata[7:0]) | st_set;
    end else begin
      stat_q <= stat_q | st_set;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_q <= dcp_pkg::MASK_RST;
      fc_q <= dcp_pkg::FC_RST;
    end else begin
      if (wr && paddr == dcp_pkg::OFS_MASK) mask_q <= pwdata[7:0];
      if (wr && paddr == dcp_pkg::OFS_FC) fc_q <= pwdata[7:0];
    end
  end

  // ------------------------------------------------------------
  // apb read path
  // ------------------------------------------------------------
  // data latched in setup so the access phase needs no wait
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_q <= 32'h0;
      err_q <= 1'h0;
    end else if (psel && !penable) begin
      err_q <= 1'h0;
      case (paddr)
        dcp_pkg::OFS_MODE: prdata_q <= {16'h0, mode_q[15:1], run_q};
        dcp_pkg::OFS_SRC: prdata_q <= src_q;
        dcp_pkg::OFS_DST: prdata_q <= dst_q;
        dcp_pkg::OFS_FC: prdata_q <= {24'h0, fc_q};
        dcp_pkg::OFS_CNT: prdata_q <= cnt_q;
        dcp_pkg::OFS_STAT: prdata_q <= {24'h0, stat_q};
        dcp_pkg::OFS_MASK: prdata_q <= {24'h0, mask_q};
        default: begin
          prdata_q <= 32'h0;
          err_q <= 1'h1;
        end
      endcase
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'h1;
  assign pslverr = psel && penable && err_q;
  assign bus_req = bus_req_q;
  assign bus_cmd = bus_cmd_q;
  assign space_code_outputs = bus_cmd_q.space;
  assign buffer_served = served_q;
  assign periph_acknowledge_n = ack_n_q;
  assign transfer_end_n_out = 1'h0;
  assign transfer_end_n_oe = drv_q;
  assign chan_irq = |(stat_q & mask_q);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking dcp_cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  AST_INT_START: assert property (
    ($rose(run_q) && state_q == ST_IDLE && held_q == 3'h0 && !stop_q &&
     mode_q[dcp_pkg::M_REQ+:2] == dcp_pkg::REQ_MAX && end_s2 && !srst)
    |=> bus_req_q) else $error("internal start did not issue a cycle");
  AST_REQ_NEEDS_RUN: assert property (
    $rose(bus_req_q) |-> $past(run_q))
    else $error("bus cycle issued while stopped");
  AST_STOP_HOLDS: assert property (
    (stop_q && held_q != 3'h0 && !srst && !berr && !fin && !ext_end)
    |-> run_q ##1 run_q)
    else $error("run bit dropped mid operand");
  AST_SRC_ADDR: assert property (
    (bus_req_q && !bus_cmd_q.write) |-> bus_cmd_q.addr == src_q)
    else $error("read address differs from source pointer");
  AST_SRC_STEP: assert property (
    (rbeat && mode_q[dcp_pkg::M_SINC] && !srst)
    |=> src_q == $past(src_q) + 32'($past(nb)))
    else $error("source pointer step wrong");
  AST_DST_ADDR: assert property (
    (bus_req_q && bus_cmd_q.write) |-> bus_cmd_q.addr == dst_q)
    else $error("write address differs from destination pointer");
  AST_SPACE: assert property (
    ($rose(bus_req_q) && $stable(fc_q)) |-> space_code_outputs ==
    (bus_cmd_q.write ? fc_q[7:4] : fc_q[3:0]))
    else $error("space code nibble wrong");
  AST_CNT_STEP: assert property (
    wbeat |=> cnt_q == $past(cnt_q) - 32'($past(nb)))
    else $error("byte count step wrong");
  AST_W1C: assert property (
    (wr && paddr == dcp_pkg::OFS_STAT && pwdata[dcp_pkg::S_DONE] &&
     !ev_done) |=> !stat_q[dcp_pkg::S_DONE])
    else $error("write one did not clear done");
  AST_SET_WINS: assert property (
    (ev_done && !srst) |=> stat_q[dcp_pkg::S_DONE])
    else $error("done event lost");
  AST_BERR: assert property (
    berr |-> !ev_done ##1 (!run_q && !bus_req_q))
    else $error("bus error did not stop the channel");
  AST_ACK: assert property (
    (bus_req_q && $stable(mode_q) && ext &&
     bus_cmd_q.write != mode_q[dcp_pkg::M_PSRC]) |-> !periph_acknowledge_n)
    else $error("acknowledge missing on peripheral access");
  AST_END_DRIVE: assert property (
    (bus_req_q && bus_cmd_q.write && cnt33 == 33'(nb)) |-> transfer_end_n_oe)
    else $error("end line not driven on final write");

  COV_DONE: cover property (ev_done ##1 chan_irq);
  COV_PACK: cover property (rbeat ##[1:8] rbeat ##[1:8] wbeat);
  COV_UNPACK: cover property (wbeat && held_q > nb);
  COV_BERR: cover property (berr && bus_cmd_q.write);
endmodule

// >>> bench/dcp_far_side.sv
// dcp_far_side: memory slave on the channel system bus
// assumes the bench preloads every byte that the channel reads
`timescale 1ns/1ps
module dcp_far_side #(
  parameter logic [31:0] ERR_ADDR = 32'h400
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic bus_req,
  input wire dcp_pkg::dcp_bus_cmd_t bus_cmd,
  input wire logic [3:0] space_code_outputs,
  input wire logic periph_acknowledge_n,
  input wire logic transfer_end_n_oe,
  input wire logic [3:0] slow,
  input wire logic err_on,
  output logic bus_ack,
  output logic bus_err,
  output logic [31:0] bus_rdata
);
  // ----------------------
  // byte memory and answers
  // ----------------------
  logic [7:0] mem [logic [31:0]];
  logic [3:0] rd_space_q;
  logic [3:0] wr_space_q;
  logic wr_ackn_q;
  logic end_oe_q;
  logic [3:0] wait_q;

  // rdata toggles when not valid, so a stale read never matches
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_ack <= 1'b0;
      bus_err <= 1'b0;
      bus_rdata <= 32'h0;
      wait_q <= 4'h0;
    end else begin
      bus_ack <= 1'b0;
      bus_err <= 1'b0;
      bus_rdata <= ~bus_rdata;
      if (bus_req && !bus_ack && !bus_err) begin
        wait_q <= wait_q + 4'h1;
        if (wait_q >= slow) begin
          wait_q <= 4'h0;
          if (err_on && bus_cmd.addr == ERR_ADDR) begin
            bus_err <= 1'b1;
          end else begin
            bus_ack <= 1'b1;
            for (int i = 0; i < int'(bus_cmd.nbytes); i++) begin
              if (bus_cmd.write) begin
                mem[bus_cmd.addr + 32'(i)] = bus_cmd.wdata[8*i +: 8];
              end else begin
                bus_rdata[8*i +: 8] <= mem[bus_cmd.addr + 32'(i)];
              end
            end
            if (bus_cmd.write) begin
              wr_space_q <= space_code_outputs;
              wr_ackn_q <= periph_acknowledge_n;
              end_oe_q <= transfer_end_n_oe;
            end else begin
              rd_space_q <= space_code_outputs;
            end
          end
        end
      end
    end
  end
endmodule

// >>> bench/tb_top.sv
// tb_top: apb-level tests of one dma channel
// assumes dcp_far_side answers bus cycles; bench drives the pins
`timescale 1ns/1ps
module tb_top;
  // ----------------------
  // signals and instances
  // ----------------------
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic bus_req;
  dcp_pkg::dcp_bus_cmd_t bus_cmd;
  logic bus_ack;
  logic bus_err;
  logic [31:0] bus_rdata;
  logic [3:0] space_code_outputs;
  logic desc_load = 1'b0;
  dcp_pkg::dcp_desc_t desc_in = '0;
  logic desc_none = 1'b0;
  logic breakpoint = 1'b0;
  logic periph_request_n = 1'b1;
  logic periph_acknowledge_n;
  logic transfer_end_n_out;
  logic transfer_end_n_oe;
  logic end_pull = 1'b0;
  logic chan_irq;
  logic buffer_served;
  logic [1:0] served_n = 2'h0;
  logic [3:0] slow = 4'h0;
  logic err_on = 1'b0;
  logic last_err;
  logic [31:0] r;
  logic [31:0] c;
  int checks = 0;
  int miscompares = 0;
  // open-drain end line with pull-up
  wire transfer_end_n_in = ~((transfer_end_n_oe & ~transfer_end_n_out)
                             | end_pull);

  always #10 sys_clk = ~sys_clk;

  // count buffers finished under microcode control
  always @(posedge sys_clk) begin
    if (reset_n && buffer_served) served_n <= served_n + 2'h1;
  end

  // gap shortened so limited-rate runs stay brief
  dcp_channel #(.GAP(2)) dcp_channel_i (
    .sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .bus_req, .bus_cmd, .bus_ack, .bus_err,
    .bus_rdata, .space_code_outputs, .desc_load, .desc_in, .desc_none,
    .buffer_served, .breakpoint, .periph_request_n,
    .periph_acknowledge_n, .transfer_end_n_in, .transfer_end_n_out,
    .transfer_end_n_oe, .chan_irq);

  dcp_far_side dcp_far_side_i (
    .sys_clk, .reset_n, .bus_req, .bus_cmd, .space_code_outputs,
    .periph_acknowledge_n, .transfer_end_n_oe, .slow, .err_on,
    .bus_ack, .bus_err, .bus_rdata);

  // ----------------------
  // access and compare tasks
  // ----------------------
  task automatic end_of_test;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(r, e);
  endtask

  task automatic mo(input logic [1:0] rq, inc, ss, ds, input logic run);
    wr(dcp_pkg::OFS_MODE, 32'(run) | 32'(rq) << dcp_pkg::M_REQ
       | 32'(inc) << dcp_pkg::M_SINC | 32'(ss) << dcp_pkg::M_SSZ
       | 32'(ds) << dcp_pkg::M_DSZ);
  endtask

  // soft reset first, so every test starts from a clean channel
  task automatic go(input logic [31:0] s, d, n);
    wr(dcp_pkg::OFS_MODE, 32'h2);
    wr(dcp_pkg::OFS_SRC, s);
    wr(dcp_pkg::OFS_DST, d);
    wr(dcp_pkg::OFS_CNT, n);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    r = 32'h1;
    while (r[0] !== 1'b0 && n < 3000) begin
      apb(1'b0, dcp_pkg::OFS_MODE, 32'h0);
      n++;
    end
    chk({31'h0, r[0]}, 32'h0);
  endtask

  task automatic fill(input logic [31:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      dcp_far_side_i.mem[b + 32'(i)] = 8'(i * 37) ^ b[11:4];
    end
  endtask

  task automatic cmp(input logic [31:0] s, d, input int n);
    for (int i = 0; i < n; i++) begin
      chk({24'h0, dcp_far_side_i.mem[d + 32'(i)]},
          {24'h0, dcp_far_side_i.mem[s + 32'(i)]});
    end
  endtask

  // ----------------------
  // test sequence
  // ----------------------
  initial begin
    #1000000;
    miscompares++;
    end_of_test;
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    rc(dcp_pkg::OFS_MODE, 32'h0);
    rc(dcp_pkg::OFS_FC, 32'h0);
    rc(dcp_pkg::OFS_STAT, 32'h0);
    rc(dcp_pkg::OFS_MASK, 32'h0);
    rc(8'h1C, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    // byte source packed into word writes
    fill(32'h100, 16);
    go(32'h100, 32'h200, 32'd6);
    wr(dcp_pkg::OFS_FC, 32'hA5);
    wr(dcp_pkg::OFS_MASK, 32'h1);
    mo(dcp_pkg::REQ_MAX, 2'h3, 2'h1, 2'h2, 1'b1);
    wait_idle;
    rc(dcp_pkg::OFS_SRC, 32'h106);
    rc(dcp_pkg::OFS_DST, 32'h206);
    rc(dcp_pkg::OFS_CNT, 32'h0);
    rc(dcp_pkg::OFS_STAT, 32'h1);
    chk({31'h0, chan_irq}, 32'h1);
    cmp(32'h100, 32'h200, 6);
    chk({28'h0, dcp_far_side_i.rd_space_q}, 32'h5);
    chk({28'h0, dcp_far_side_i.wr_space_q}, 32'hA);
    chk({31'h0, dcp_far_side_i.end_oe_q}, 32'h1);
    wr(dcp_pkg::OFS_STAT, 32'h0);
    rc(dcp_pkg::OFS_STAT, 32'h1);
    wr(dcp_pkg::OFS_STAT, 32'hFF);
    rc(dcp_pkg::OFS_STAT, 32'h0);
    chk({31'h0, chan_irq}, 32'h0);
    // long words across the top of the address space
    fill(32'hFFFFFFFC, 8);
    go(32'hFFFFFFFC, 32'h300, 32'd8);
    mo(dcp_pkg::REQ_LIMITED, 2'h3, 2'h0, 2'h0, 1'b1);
    wait_idle;
    rc(dcp_pkg::OFS_SRC, 32'h4);
    rc(dcp_pkg::OFS_DST, 32'h308);
    cmp(32'hFFFFFFFC, 32'h300, 8);
    // read error, then write error
    err_on <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      go(k ? 32'h100 : 32'h400, k ? 32'h400 : 32'h500, 32'd4);
      mo(dcp_pkg::REQ_MAX, 2'h3, 2'h0, 2'h0, 1'b1);
      wait_idle;
      rc(dcp_pkg::OFS_STAT, k ? 32'h2 : 32'h4);
    end
    err_on <= 1'b0;
    wr(dcp_pkg::OFS_MODE, 32'h2);
    rc(dcp_pkg::OFS_STAT, 32'h0);
    rc(dcp_pkg::OFS_MODE, 32'h0);
    // stop mid-block, then resume with breakpoint held
    slow <= 4'h6;
    go(32'h100, 32'h600, 32'd16);
    mo(dcp_pkg::REQ_MAX, 2'h3, 2'h1, 2'h1, 1'b1);
    repeat (40) @(posedge sys_clk);
    mo(dcp_pkg::REQ_MAX, 2'h3, 2'h1, 2'h1, 1'b0);
    wait_idle;
    apb(1'b0, dcp_pkg::OFS_CNT, 32'h0);
    c = r;
    rc(dcp_pkg::OFS_SRC, 32'h110 - c);
    rc(dcp_pkg::OFS_DST, 32'h610 - c);
    chk({31'h0, c == 32'h0}, 32'h0);
    breakpoint <= 1'b1;
    mo(dcp_pkg::REQ_MAX, 2'h3, 2'h1, 2'h1, 1'b1);
    wait_idle;
    breakpoint <= 1'b0;
    cmp(32'h100, 32'h600, 16);
    rc(dcp_pkg::OFS_STAT, 32'h11);
    // external end line cuts an internal block short
    go(32'h100, 32'h900, 32'd16);
    mo(dcp_pkg::REQ_MAX, 2'h3, 2'h1, 2'h1, 1'b1);
    repeat (40) @(posedge sys_clk);
    end_pull <= 1'b1;
    wait_idle;
    end_pull <= 1'b0;
    slow <= 4'h0;
    rc(dcp_pkg::OFS_STAT, 32'h1);
    apb(1'b0, dcp_pkg::OFS_CNT, 32'h0);
    chk({31'h0, r == 32'h0}, 32'h0);
    // level request: ignored while stopped, fixed destination
    go(32'h100, 32'h800, 32'd4);
    mo(dcp_pkg::REQ_LEVEL, 2'h1, 2'h1, 2'h1, 1'b0);
    periph_request_n <= 1'b0;
    repeat (30) @(posedge sys_clk);
    rc(dcp_pkg::OFS_CNT, 32'h4);
    mo(dcp_pkg::REQ_LEVEL, 2'h1, 2'h1, 2'h1, 1'b1);
    wait_idle;
    periph_request_n <= 1'b1;
    rc(dcp_pkg::OFS_DST, 32'h800);
    cmp(32'h103, 32'h800, 1);
    chk({31'h0, dcp_far_side_i.wr_ackn_q}, 32'h0);
    // edge request: one falling edge moves one operand
    go(32'h100, 32'hB00, 32'd4);
    mo(dcp_pkg::REQ_EDGE, 2'h3, 2'h1, 2'h1, 1'b1);
    periph_request_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    periph_request_n <= 1'b1;
    repeat (60) @(posedge sys_clk);
    rc(dcp_pkg::OFS_CNT, 32'h3);
    // microcode mode: flagged buffer, none left, then last buffer
    go(32'h0, 32'h0, 32'h0);
    wr(dcp_pkg::OFS_MODE, 32'h434);
    desc_in <= {32'h100, 32'hA00, 32'd8, 1'b1, 1'b0};
    desc_load <= 1'b1;
    @(posedge sys_clk);
    desc_load <= 1'b0;
    wr(dcp_pkg::OFS_MODE, 32'h435);
    repeat (40) @(posedge sys_clk);
    rc(dcp_pkg::OFS_SRC, 32'h108);
    rc(dcp_pkg::OFS_DST, 32'hA08);
    rc(dcp_pkg::OFS_STAT, 32'h20);
    // out of descriptors only counts while waiting for the next one
    desc_none <= 1'b1;
    @(posedge sys_clk);
    desc_none <= 1'b0;
    wait_idle;
    rc(dcp_pkg::OFS_STAT, 32'h28);
    desc_in <= {32'h108, 32'hA08, 32'd8, 1'b0, 1'b1};
    desc_load <= 1'b1;
    @(posedge sys_clk);
    desc_load <= 1'b0;
    wr(dcp_pkg::OFS_MODE, 32'h435);
    wait_idle;
    rc(dcp_pkg::OFS_STAT, 32'h29);
    chk({30'h0, served_n}, 32'h2);
    end_of_test;
  end
endmodule
